// ===== rtl/fbk_pkg.sv
package fbk_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_INDEX = 8'h08;
    localparam logic [7:0] OFF_PARAM = 8'h0c;
    localparam logic [7:0] OFF_SECURITY = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
    localparam logic [7:0] OFF_IRQ_EN = 8'h1c;
    localparam logic [7:0] OFF_MARGIN = 8'h20;
    // configuration fields
    localparam int WS_LSB = 2;
    localparam logic [1:0] WS_RESET = 2'h3;
    // status fields
    localparam int ST_CCF = 7;
    localparam int ST_ACC = 5;
    localparam int ST_PV = 4;
    localparam int ST_MG1 = 1;
    localparam int ST_MG0 = 0;
    // security fields
    localparam int SEC_KEY_ACCESS_ENABLE_LSB = 6;
    localparam logic [1:0] KEY_ACCESS_ENABLE_ON = 2'h2;
    localparam int SEC_SECURED = 0;
    // commands
    localparam logic [7:0] CMD_VERIFY_KEY = 8'h0c;
    localparam logic [7:0] CMD_SET_MARGIN = 8'h0d;
    localparam logic [2:0] IDX_VERIFY_KEY = 3'h4;
    localparam logic [2:0] IDX_SET_MARGIN = 3'h1;
    // stored comparison key base address
    localparam logic [23:0] KEY_BASE = 24'hff_fe00;
    localparam int NUM_KEYS = 4;
    // interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    typedef enum logic [1:0] {
        FBK_IDLE,
        FBK_CHECK,
        FBK_COMPARE,
        FBK_FINISH
    } fbk_state_e;
endpackage : fbk_pkg

// ===== rtl/fbk_ctrl.sv
`timescale 1ns/1ps
// Operation
// - read wait states follow config bits 3:2 on every flash read
// - wait-state field resets to the largest setting
// - writes to wait-state field ignored while a command runs
// - verify launch checks key-enable field; not 10 gives access error
// - key words compared with stored key starting at 0xff_fe00
// - all four keys matching releases security
// - after mismatch every later verify attempt errors until reset
// - command-complete flag sets when verify finishes, match or not
// - parameter index other than 100 at verify launch gives access error
// - incorrect key sets access error
// - margin command applies level to later reads of addressed block
module fbk_ctrl #(
    parameter int KEY_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [1:0] read_wait_states,
    output logic [23:0] key_addr,
    input wire logic [15:0] key_data,
    output logic secured,
    output logic [23:0] margin_block_addr,
    output logic [1:0] margin_level,
    output logic irq
);
    if (KEY_W != 16) begin : g_key_w_check
        $error("key words must be 16 bits");
    end

    logic [7:0] config_reg;
    logic [7:0] status_reg;
    logic [2:0] index_reg;
    logic [15:0] param_reg [0:7];
    logic [7:0] security_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_en_reg;
    logic [1:0] margin_req_reg;
    logic mismatch_reg;
    logic match_reg;
    logic [2:0] key_cnt_reg;
    fbk_pkg::fbk_state_e state_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic launch;
    logic done_ev;
    logic err_ev;
    logic busy;

    assign busy = (state_reg != fbk_pkg::FBK_IDLE);

    // bus address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    logic wr;
    assign wr = wr_pend_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read data registered in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                fbk_pkg::OFF_CONFIG: hrdata <= {24'h0, config_reg};
                fbk_pkg::OFF_STATUS: hrdata <= {24'h0, status_reg};
                fbk_pkg::OFF_INDEX: hrdata <= {29'h0, index_reg};
                fbk_pkg::OFF_PARAM: hrdata <= {16'h0, param_reg[index_reg]};
                fbk_pkg::OFF_SECURITY: hrdata <= {24'h0, security_reg};
                fbk_pkg::OFF_IRQ_STAT: hrdata <= {30'h0, irq_stat_reg};
                fbk_pkg::OFF_IRQ_EN: hrdata <= {30'h0, irq_en_reg};
                fbk_pkg::OFF_MARGIN: hrdata <= {30'h0, margin_req_reg};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // configuration: wait-state field only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            config_reg <= {4'h0, fbk_pkg::WS_RESET, 2'h0};
        end else if (wr && wr_addr_reg == fbk_pkg::OFF_CONFIG && !busy) begin
            config_reg[fbk_pkg::WS_LSB +: 2] <= hwdata[fbk_pkg::WS_LSB +: 2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_wait_states <= fbk_pkg::WS_RESET;
        end else begin
            read_wait_states <= config_reg[fbk_pkg::WS_LSB +: 2];
        end
    end

    // parameter index and words, frozen while busy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            index_reg <= 3'h0;
            margin_req_reg <= 2'h0;
            for (int i = 0; i < 8; i++) param_reg[i] <= 16'h0000;
        end else if (wr && !busy) begin
            if (wr_addr_reg == fbk_pkg::OFF_INDEX) begin
                index_reg <= hwdata[2:0];
            end
            if (wr_addr_reg == fbk_pkg::OFF_PARAM) begin
                param_reg[index_reg] <= hwdata[15:0];
            end
            if (wr_addr_reg == fbk_pkg::OFF_MARGIN) begin
                margin_req_reg <= hwdata[1:0];
            end
        end
    end

    // security register: software sets key-enable, hardware owns secure bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            security_reg <= 8'h01;
        end else if (state_reg == fbk_pkg::FBK_FINISH && match_reg
                     && !mismatch_reg) begin
            security_reg[fbk_pkg::SEC_SECURED] <= 1'b0;
        end else if (wr && wr_addr_reg == fbk_pkg::OFF_SECURITY && !busy) begin
            security_reg[fbk_pkg::SEC_KEY_ACCESS_ENABLE_LSB +: 2] <=
                hwdata[fbk_pkg::SEC_KEY_ACCESS_ENABLE_LSB +: 2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            secured <= 1'b1;
        end else begin
            secured <= security_reg[fbk_pkg::SEC_SECURED];
        end
    end

    // writing 1 to the complete flag while it is set launches a command
    assign launch = wr && wr_addr_reg == fbk_pkg::OFF_STATUS && !busy
                    && hwdata[fbk_pkg::ST_CCF];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= fbk_pkg::FBK_IDLE;
            key_cnt_reg <= 3'h0;
            match_reg <= 1'b0;
            key_addr <= fbk_pkg::KEY_BASE;
        end else begin
            case (state_reg)
                fbk_pkg::FBK_IDLE: begin
                    if (launch) state_reg <= fbk_pkg::FBK_CHECK;
                end
                fbk_pkg::FBK_CHECK: begin
                    key_cnt_reg <= 3'h0;
                    match_reg <= 1'b1;
                    key_addr <= fbk_pkg::KEY_BASE;
                    if (param_reg[0][15:8] == fbk_pkg::CMD_VERIFY_KEY
                        && index_reg == fbk_pkg::IDX_VERIFY_KEY
                        && security_reg[fbk_pkg::SEC_KEY_ACCESS_ENABLE_LSB +: 2]
                           == fbk_pkg::KEY_ACCESS_ENABLE_ON
                        && !mismatch_reg) begin
                        state_reg <= fbk_pkg::FBK_COMPARE;
                    end else begin
                        match_reg <= 1'b0;
                        state_reg <= fbk_pkg::FBK_FINISH;
                    end
                end
                fbk_pkg::FBK_COMPARE: begin
                    // key_addr was set last cycle; key_data answers it
                    if (key_data != param_reg[key_cnt_reg + 3'h1]) begin
                        match_reg <= 1'b0;
                    end
                    key_addr <= key_addr + 24'h000002;
                    key_cnt_reg <= key_cnt_reg + 3'h1;
                    if (key_cnt_reg == 3'(fbk_pkg::NUM_KEYS - 1)) begin
                        state_reg <= fbk_pkg::FBK_FINISH;
                    end
                end
                fbk_pkg::FBK_FINISH: state_reg <= fbk_pkg::FBK_IDLE;
                default: state_reg <= fbk_pkg::FBK_IDLE;
            endcase
        end
    end

    // margin command: 0x0d plus address words, index 001
    logic margin_ok;
    assign margin_ok = param_reg[0][15:8] == fbk_pkg::CMD_SET_MARGIN
                       && index_reg == fbk_pkg::IDX_SET_MARGIN;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            margin_block_addr <= 24'h000000;
            margin_level <= 2'h0;
        end else if (state_reg == fbk_pkg::FBK_CHECK && margin_ok) begin
            margin_block_addr <= {param_reg[0][7:0], param_reg[1]};
            margin_level <= margin_req_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mismatch_reg <= 1'b0;
        end else if (state_reg == fbk_pkg::FBK_COMPARE
                     && key_data != param_reg[key_cnt_reg + 3'h1]) begin
            mismatch_reg <= 1'b1;
        end
    end

    assign done_ev = (state_reg == fbk_pkg::FBK_FINISH);
    assign err_ev = done_ev && !match_reg
                    && !(param_reg[0][15:8] == fbk_pkg::CMD_SET_MARGIN
                         && margin_ok);

    // status: complete flag, access error; protection/margin flags stay 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= 8'h80;
        end else if (launch) begin
            status_reg[fbk_pkg::ST_CCF] <= 1'b0;
            status_reg[fbk_pkg::ST_ACC] <= 1'b0;
        end else if (done_ev) begin
            status_reg[fbk_pkg::ST_CCF] <= 1'b1;
            if (err_ev) status_reg[fbk_pkg::ST_ACC] <= 1'b1;
        end else if (wr && wr_addr_reg == fbk_pkg::OFF_STATUS
                     && hwdata[fbk_pkg::ST_ACC]) begin
            status_reg[fbk_pkg::ST_ACC] <= 1'b0;
        end
    end

    // interrupts: set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= 2'h0;
            irq_en_reg <= 2'h0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if ((b == fbk_pkg::IRQ_DONE && done_ev)
                    || (b == fbk_pkg::IRQ_ERR && err_ev)) begin
                    irq_stat_reg[b] <= 1'b1;
                end else if (wr && wr_addr_reg == fbk_pkg::OFF_IRQ_CLR
                             && hwdata[b]) begin
                    irq_stat_reg[b] <= 1'b0;
                end
            end
            if (wr && wr_addr_reg == fbk_pkg::OFF_IRQ_EN) begin
                irq_en_reg <= hwdata[1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

    property p_ws_hold;
        @(posedge hclk) disable iff (!hresetn)
        busy |=> $stable(config_reg);
    endproperty
    a_ws_hold: assert property (p_ws_hold)
        else $error("ws changed busy");

    property p_ws_out;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> read_wait_states == $past(config_reg[3:2]);
    endproperty
    a_ws_out: assert property (p_ws_out)
        else $error("ws out wrong");

    property p_done;
        @(posedge hclk) disable iff (!hresetn)
        launch |-> ##[2:7] status_reg[fbk_pkg::ST_CCF];
    endproperty
    a_done: assert property (p_done)
        else $error("no complete");

    property p_key_access_enable;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == fbk_pkg::FBK_CHECK
         && param_reg[0][15:8] == fbk_pkg::CMD_VERIFY_KEY
         && security_reg[fbk_pkg::SEC_KEY_ACCESS_ENABLE_LSB +: 2] != fbk_pkg::KEY_ACCESS_ENABLE_ON)
        |-> ##2 status_reg[fbk_pkg::ST_ACC];
    endproperty
    a_key_access_enable: assert property (p_key_access_enable)
        else $error("key_access_enable no err");

    property p_index;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == fbk_pkg::FBK_CHECK && index_reg != 3'h4
         && param_reg[0][15:8] == 8'h0c) |-> ##2 status_reg[fbk_pkg::ST_ACC];
    endproperty
    a_index: assert property (p_index)
        else $error("index no err");

    property p_sticky;
        @(posedge hclk) disable iff (!hresetn)
        mismatch_reg |=> mismatch_reg;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("mismatch lost");

    property p_locked;
        @(posedge hclk) disable iff (!hresetn)
        mismatch_reg |-> !$fell(security_reg[0]);
    endproperty
    a_locked: assert property (p_locked)
        else $error("unlocked");

    property p_flags;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |-> status_reg[4] == 1'b0 && status_reg[1:0] == 2'h0;
    endproperty
    a_flags: assert property (p_flags)
        else $error("flags moved");

    property p_mismatch_err;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == fbk_pkg::FBK_FINISH && !match_reg
         && param_reg[0][15:8] == fbk_pkg::CMD_VERIFY_KEY)
        |=> status_reg[fbk_pkg::ST_ACC];
    endproperty
    a_mismatch_err: assert property (p_mismatch_err)
        else $error("no err");
endmodule : fbk_ctrl

// ===== verif/fbk_key_mem.sv
`timescale 1ns/1ps
module fbk_key_mem #(
    parameter logic [63:0] KEYS = 64'h0
) (
    input wire logic [23:0] key_addr,
    output logic [15:0] key_data
);
    logic [23:0] off;
    assign off = key_addr - fbk_pkg::KEY_BASE;
    // key word n sits at base + 2n; any other address returns junk
    always_comb begin
        if (off < 24'h8 && off[0] == 1'b0)
            key_data = KEYS[16 * off[2:1] +: 16];
        else
            key_data = ~key_addr[15:0];
    end
endmodule : fbk_key_mem

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam logic [63:0] KEYS = 64'h3c5a_9e17_4b82_d6f1;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, s, seed;
    logic [1:0] htrans, read_wait_states, margin_level, ws_exp, lvl;
    logic [2:0] hsize;
    logic [23:0] key_addr, margin_block_addr;
    logic [15:0] key_data;
    logic secured, irq, rd_dp;
    logic [15:0] pw [5];
    logic [31:0] exp_q[$], msk_q[$];
    string nm_q[$];
    int err_count, cmp_count;
    assign hready = hreadyout;
    fbk_ctrl fbk_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .read_wait_states(read_wait_states), .key_addr(key_addr),
        .key_data(key_data), .secured(secured),
        .margin_block_addr(margin_block_addr),
        .margin_level(margin_level), .irq(irq));
    fbk_key_mem #(.KEYS(KEYS)) fbk_key_mem_i (.key_addr(key_addr),
        .key_data(key_data));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return (v >> 1) ^ (v[0] ? 32'h8020_0003 : 32'h0);
    endfunction : lfsr
    task automatic conclude();
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic cmp(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            err_count++;
        end
    endtask : cmp
    task automatic wt();
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
    endtask : wt
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, input logic c,
                       output logic [31:0] q);
        if (hclk === 1'b0)
            @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= c;
        wt();
        q = hrdata;
        rd_dp <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, 1'b0, q);
    endtask : wr
    task automatic rd(input string n, input logic [7:0] a,
                      input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        nm_q.push_back(n);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(a, 1'b0, 32'h0, 1'b1, q);
    endtask : rd
    task automatic settle();
        repeat (2) @(posedge hclk);
        @(negedge hclk);
    endtask : settle
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        ws_exp = fbk_pkg::WS_RESET;
    endtask : do_reset
    task automatic load(input int n);
        for (int i = 0; i < n; i++) begin
            wr(fbk_pkg::OFF_INDEX, 32'(i));
            wr(fbk_pkg::OFF_PARAM, {16'h0, pw[i]});
        end
    endtask : load
    // launch, then try to move the wait states while busy
    task automatic run(input logic [31:0] st);
        wr(fbk_pkg::OFF_STATUS, 32'h80);
        wr(fbk_pkg::OFF_CONFIG, {28'h0, ~ws_exp, 2'h0});
        s = 32'h0;
        while (s[fbk_pkg::ST_CCF] !== 1'b1)
            bus(fbk_pkg::OFF_STATUS, 1'b0, 32'h0, 1'b0, s);
        rd("status", fbk_pkg::OFF_STATUS, st, 32'hb3);
        rd("config", fbk_pkg::OFF_CONFIG, {28'h0, ws_exp, 2'h0}, 32'hc);
    endtask : run
    always @(posedge hclk) begin
        if (rd_dp === 1'b1 && hreadyout === 1'b1) begin
            cmp(nm_q.pop_front(), exp_q.pop_front(),
                hrdata & msk_q.pop_front());
            cmp("hresp", 32'h0, {31'h0, hresp});
        end
    end
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    initial begin
        #100000;
        err_count++;
        conclude();
    end
    initial begin
        {hsel, hwrite, rd_dp, hresetn} = 4'h0;
        {haddr, hwdata, htrans, hsize} = 69'h0;
        err_count = 0;
        cmp_count = 0;
        seed = 32'h0001_3a21;
        do_reset();
        rd("config", fbk_pkg::OFF_CONFIG, {28'h0, ws_exp, 2'h0}, 32'hc);
        rd("status", fbk_pkg::OFF_STATUS, 32'h80, 32'hb3);
        rd("secure", fbk_pkg::OFF_SECURITY, 32'h1, 32'h1);
        rd("unmapped", 8'h40, 32'h0, 32'hffff_ffff);
        seed = lfsr(seed);
        // flip one bit so the new setting differs from the reset value
        ws_exp = seed[1:0] ^ 2'h2;
        wr(fbk_pkg::OFF_CONFIG, {28'h0, ws_exp, 2'h0});
        settle();
        cmp("wait_states", {30'h0, ws_exp}, {30'h0, read_wait_states});
        pw[0] = {fbk_pkg::CMD_VERIFY_KEY, 8'h00};
        for (int i = 0; i < 4; i++)
            pw[i + 1] = KEYS[16 * i +: 16];
        wr(fbk_pkg::OFF_IRQ_EN, 32'h0);
        wr(fbk_pkg::OFF_SECURITY, 32'h40);
        load(5);
        run(32'ha0);
        settle();
        cmp("irq_masked", 32'h0, {31'h0, irq});
        wr(fbk_pkg::OFF_IRQ_EN, 32'h2);
        settle();
        cmp("irq_on", 32'h1, {31'h0, irq});
        wr(fbk_pkg::OFF_IRQ_CLR, 32'h3);
        settle();
        cmp("irq_off", 32'h0, {31'h0, irq});
        rd("irq_stat", fbk_pkg::OFF_IRQ_STAT, 32'h0, 32'h3);
        wr(fbk_pkg::OFF_SECURITY, 32'h80);
        seed = lfsr(seed);
        pw[2] = KEYS[31:16] ^ (seed[15:0] | 16'h1);
        load(5);
        run(32'ha0);
        pw[2] = KEYS[31:16];
        load(5);
        run(32'ha0);
        settle();
        cmp("secured", 32'h1, {31'h0, secured});
        do_reset();
        wr(fbk_pkg::OFF_SECURITY, 32'h80);
        load(5);
        wr(fbk_pkg::OFF_INDEX, 32'h3);
        run(32'ha0);
        wr(fbk_pkg::OFF_INDEX, 32'h4);
        run(32'h80);
        settle();
        cmp("released", 32'h0, {31'h0, secured});
        rd("secure", fbk_pkg::OFF_SECURITY, 32'h80, 32'hc1);
        seed = lfsr(seed);
        lvl = seed[1:0];
        pw[0] = {fbk_pkg::CMD_SET_MARGIN, seed[23:16]};
        pw[1] = seed[31:16];
        wr(fbk_pkg::OFF_MARGIN, {30'h0, lvl});
        load(2);
        run(32'h80);
        settle();
        cmp("margin_addr", {8'h0, pw[0][7:0], pw[1]},
            {8'h0, margin_block_addr});
        cmp("margin_lvl", {30'h0, lvl}, {30'h0, margin_level});
        conclude();
    end
endmodule : testbench
